// >>> sfcl_pkg.sv
// Package for the serial flash configuration loader.
// Holds record offsets, tag value, field positions and decode codes.
package sfcl_pkg;
  // Record word offsets (bytes)
  localparam logic [8:0] OFF_TAG       = 9'h000;
  localparam logic [8:0] OFF_A_CS0_CAP = 9'h034;
  localparam logic [8:0] OFF_A_CS1_CAP = 9'h038;
  localparam logic [8:0] OFF_B_CS0_CAP = 9'h03C;
  localparam logic [8:0] OFF_B_CS1_CAP = 9'h040;
  localparam logic [8:0] OFF_CLK_FREQ  = 9'h044;
  localparam logic [8:0] OFF_BUSY      = 9'h048;
  localparam logic [8:0] OFF_LANES     = 9'h04C;
  localparam logic [8:0] OFF_PORTS     = 9'h050;
  localparam logic [8:0] OFF_DDR       = 9'h054;
  localparam logic [8:0] OFF_A_CS1_EN  = 9'h060;
  localparam logic [8:0] OFF_LAST      = 9'h060;
  localparam logic [8:0] OFF_STEP      = 9'h004;
  // Magic tag, lowest byte first
  localparam logic [31:0] TAG_VALUE    = 32'h6663716B;
  // Busy word fields
  localparam int BUSY_POL_LSB = 16;
  localparam int BUSY_POS_MSB = 4;
  // Decode codes
  localparam logic [31:0] CODE_ZERO  = 32'h00000000;
  localparam logic [31:0] CODE_ONE   = 32'h00000001;
  localparam logic [31:0] CODE_TWO   = 32'h00000002;
  localparam logic [31:0] CODE_THREE = 32'h00000003;
  typedef enum logic [1:0] {
    SFCL_CLK_LOW  = 2'h0,
    SFCL_CLK_MID  = 2'h1,
    SFCL_CLK_HIGH = 2'h2
  } sfcl_clk_type;
  typedef enum logic [1:0] {
    SFCL_LANE_1 = 2'h0,
    SFCL_LANE_2 = 2'h1,
    SFCL_LANE_4 = 2'h2,
    SFCL_LANE_8 = 2'h3
  } sfcl_lane_type;
endpackage

// >>> sfcl_busy_check.sv
// Busy decision for status polling of the external flash.
// Assumes status word and settings come from the same clock domain.
`timescale 1ns/1ps
module sfcl_busy_check (
  // Status word from flash
  input  wire logic [31:0] status_word,
  // Configured busy flag
  input  wire logic [4:0]  busy_position,
  input  wire logic        busy_level,
  // Result
  output logic             flash_busy
);
  always_comb begin
    flash_busy = (status_word[busy_position] == busy_level);
  end
endmodule

// >>> sfcl_loader.sv
// Serial flash configuration loader: walks the setup record words and
// turns them into flash controller settings.
// Assumes a word reader answering one request with one data pulse.
`timescale 1ns/1ps
module sfcl_loader
  import sfcl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Control
  input  wire logic                  load_start,
  // Record word reader
  output logic                       rd_req,
  output logic [8:0]                 rd_addr,
  input  wire logic                  rd_valid,
  input  wire logic [31:0]           rd_data,
  // Status
  output logic                       load_busy,
  output logic                       load_done,
  output logic                       record_valid,
  // Decoded settings
  output logic [31:0]                port_a_cs0_capacity,
  output logic [31:0]                port_a_cs1_capacity,
  output logic [31:0]                port_b_cs0_capacity,
  output logic [31:0]                port_b_cs1_capacity,
  output logic                       port_a_cs1_present,
  output logic                       port_b_cs0_present,
  output logic                       port_b_cs1_present,
  output sfcl_pkg::sfcl_clk_type     clock_class,
  output logic                       busy_level,
  output logic [4:0]                 busy_position,
  output sfcl_pkg::sfcl_lane_type    lane_width,
  output logic                       second_flash_port_enable,
  output logic                       ddr_enable,
  output logic                       first_port_second_select_enable,
  // Status polling
  input  wire logic [31:0]           flash_status,
  output logic                       flash_busy
);
  import sfcl_pkg::*;

  typedef enum logic [1:0] {
    SFCL_IDLE = 2'h0,
    SFCL_TAG  = 2'h1,
    SFCL_BODY = 2'h3,
    SFCL_END  = 2'h2
  } sfcl_state_type;

  sfcl_state_type state;
  logic [8:0]     addr;

  // One outstanding read; request held until data returns
  assign rd_req    = (state == SFCL_TAG) || (state == SFCL_BODY);
  assign rd_addr   = addr;
  assign load_busy = rd_req;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= SFCL_IDLE;
      addr  <= OFF_TAG;
    end else begin
      case (state)
        SFCL_IDLE: begin
          if (load_start) begin
            state <= SFCL_TAG;
            addr  <= OFF_TAG;
          end
        end
        SFCL_TAG: begin
          if (rd_valid) begin
            // Bad tag: stop at once, settings stay untouched
            if (rd_data == TAG_VALUE) begin
              state <= SFCL_BODY;
              addr  <= OFF_A_CS0_CAP;
            end else begin
              state <= SFCL_END;
            end
          end
        end
        SFCL_BODY: begin
          if (rd_valid) begin
            if (addr == OFF_LAST) begin
              state <= SFCL_END;
            end else if (addr == OFF_DDR) begin
              addr <= OFF_A_CS1_EN;
            end else begin
              addr <= addr + OFF_STEP;
            end
          end
        end
        SFCL_END: begin
          state <= SFCL_IDLE;
        end
        default: begin
          state <= SFCL_IDLE;
        end
      endcase
    end
  end

  // Completion pulse and validity flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      load_done    <= 1'b0;
      record_valid <= 1'b0;
    end else begin
      load_done <= (state == SFCL_END);
      if (state == SFCL_TAG && rd_valid) begin
        record_valid <= 1'b0;
      end else if (state == SFCL_BODY && rd_valid && addr == OFF_LAST) begin
        record_valid <= 1'b1;
      end
    end
  end

  // Capacity words
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_a_cs0_capacity <= CODE_ZERO;
      port_a_cs1_capacity <= CODE_ZERO;
      port_b_cs0_capacity <= CODE_ZERO;
      port_b_cs1_capacity <= CODE_ZERO;
    end else if (state == SFCL_BODY && rd_valid) begin
      case (addr)
        OFF_A_CS0_CAP: port_a_cs0_capacity <= rd_data;
        OFF_A_CS1_CAP: port_a_cs1_capacity <= rd_data;
        OFF_B_CS0_CAP: port_b_cs0_capacity <= rd_data;
        OFF_B_CS1_CAP: port_b_cs1_capacity <= rd_data;
        default: begin
        end
      endcase
    end
  end

  // Zero capacity reads as an absent device
  assign port_a_cs1_present = (port_a_cs1_capacity != CODE_ZERO);
  assign port_b_cs0_present = (port_b_cs0_capacity != CODE_ZERO);
  assign port_b_cs1_present = (port_b_cs1_capacity != CODE_ZERO);

  // Mode words; out-of-range codes keep the previous setting, except the busy word, always taken, and the select enable word, cleared by any code but one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clock_class                     <= SFCL_CLK_LOW;
      busy_level                      <= 1'b1;
      busy_position                   <= 5'h00;
      lane_width                      <= SFCL_LANE_1;
      second_flash_port_enable        <= 1'b0;
      ddr_enable                      <= 1'b0;
      first_port_second_select_enable <= 1'b0;
    end else if (state == SFCL_BODY && rd_valid) begin
      case (addr)
        OFF_CLK_FREQ: begin
          if (rd_data == CODE_ZERO) clock_class <= SFCL_CLK_LOW;
          else if (rd_data == CODE_ONE) clock_class <= SFCL_CLK_MID;
          else if (rd_data == CODE_TWO) clock_class <= SFCL_CLK_HIGH;
        end
        OFF_BUSY: begin
          // Polarity 0 means busy while flag is one
          busy_level    <= (rd_data[31:BUSY_POL_LSB] == 16'h0000);
          busy_position <= rd_data[BUSY_POS_MSB:0];
        end
        OFF_LANES: begin
          if (rd_data[31:2] == 30'h0) begin
            lane_width <= sfcl_lane_type'(rd_data[1:0]);
          end
        end
        OFF_PORTS: begin
          if (rd_data == CODE_ZERO) second_flash_port_enable <= 1'b0;
          else if (rd_data == CODE_ONE) begin
            second_flash_port_enable <= 1'b1;
          end
        end
        OFF_DDR: begin
          if (rd_data == CODE_ZERO) ddr_enable <= 1'b0;
          else if (rd_data == CODE_ONE) ddr_enable <= 1'b1;
        end
        OFF_A_CS1_EN: begin
          // Writer keeps this set whenever the capacity is nonzero
          first_port_second_select_enable <= (rd_data == CODE_ONE);
        end
        default: begin
        end
      endcase
    end
  end

  sfcl_busy_check u_busy (
    .status_word   (flash_status),
    .busy_position (busy_position),
    .busy_level    (busy_level),
    .flash_busy    (flash_busy)
  );

  // Checks
  sequence s_tag_refused;
    (state == SFCL_END) ##1 (load_done && !record_valid);
  endsequence

  property p_bad_tag;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_TAG && rd_valid && rd_data != TAG_VALUE)
      |=> s_tag_refused;
  endproperty
  a_bad_tag: assert property (p_bad_tag) else $error("bad tag accepted");

  property p_cap_a0;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_A_CS0_CAP)
      |=> (port_a_cs0_capacity == $past(rd_data));
  endproperty
  a_cap_a0: assert property (p_cap_a0) else $error("A cs0 size lost");

  property p_absent;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_A_CS1_CAP
      && rd_data == CODE_ZERO) |=> !port_a_cs1_present;
  endproperty
  a_absent: assert property (p_absent) else $error("A cs1 absent wrong");

  property p_b0;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_B_CS0_CAP
      && rd_data != CODE_ZERO) |=> port_b_cs0_present;
  endproperty
  a_b0: assert property (p_b0) else $error("B cs0 present wrong");

  property p_b1;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_B_CS1_CAP
      && rd_data == CODE_ZERO) |=> !port_b_cs1_present;
  endproperty
  a_b1: assert property (p_b1) else $error("B cs1 present wrong");

  property p_clk;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_CLK_FREQ
      && rd_data == CODE_TWO) |=> (clock_class == SFCL_CLK_HIGH);
  endproperty
  a_clk: assert property (p_clk) else $error("clock class wrong");

  property p_pol;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_BUSY)
      |=> (busy_level == ($past(rd_data[31:16]) == 16'h0000));
  endproperty
  a_pol: assert property (p_pol) else $error("busy polarity wrong");

  property p_lane;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_LANES
      && rd_data == CODE_THREE) |=> (lane_width == SFCL_LANE_8);
  endproperty
  a_lane: assert property (p_lane) else $error("lane width wrong");

  property p_ddr;
    @(posedge clock) disable iff (!rst_n)
    (state == SFCL_BODY && rd_valid && addr == OFF_DDR
      && rd_data[31:1] == 31'h0) |=> (ddr_enable == $past(rd_data[0]));
  endproperty
  a_ddr: assert property (p_ddr) else $error("ddr select wrong");

  property p_busy;
    @(posedge clock) disable iff (!rst_n)
    flash_busy |-> (flash_status[busy_position] == busy_level);
  endproperty
  a_busy: assert property (p_busy) else $error("busy decision wrong");
endmodule

// >>> sfcl_record_model.sv
// Setup record memory answering the loader's word reads.
// Assumes aligned offsets below 0x64; bench fills mem.
`timescale 1ns/1ps
module sfcl_record_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Answer delay
  input  wire logic [3:0]  wait_cycles,
  // Word reader
  input  wire logic        rd_req,
  input  wire logic [8:0]  rd_addr,
  output logic             rd_valid,
  output logic [31:0]      rd_data
);
  logic [31:0] mem [0:24];
  logic [3:0]  count;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      count    <= 4'h0;
      rd_data  <= 32'h5A5A5A5A;
    end else if (!rd_req || rd_valid) begin // Gap lets the address settle
      rd_valid <= 1'b0;
      count    <= 4'h0;
      rd_data  <= ~rd_data;
    end else if (count >= wait_cycles) begin
      rd_valid <= 1'b1;
      rd_data  <= mem[rd_addr[8:2]];
    end else begin
      count   <= count + 4'h1;
      rd_data <= ~rd_data;
    end
  end
endmodule

// >>> tb_top.sv
// Bench for the record loader and its busy decision.
// Assumes the record model; inputs change at falling edges.
`timescale 1ns/1ps
module tb_top;
  import sfcl_pkg::*;
  logic          clock, rst_n, load_start, rd_req, rd_valid, flash_busy;
  logic [8:0]    rd_addr;
  logic [31:0]   rd_data, flash_status, cap [0:3];
  logic          load_busy, load_done, record_valid, busy_level;
  logic          a1_on, b0_on, b1_on, port_b_on, ddr_on, a1_sel;
  logic [4:0]    busy_position;
  sfcl_clk_type  clock_class;
  sfcl_lane_type lane_width;
  logic [3:0]    wait_cycles = 4'h0;
  int            fails = 0, n_tests = 0, cycles = 0;
  sfcl_loader i_sfcl_loader (.clock(clock), .rst_n(rst_n),
    .load_start(load_start), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .load_busy(load_busy),
    .load_done(load_done), .record_valid(record_valid),
    .port_a_cs0_capacity(cap[0]), .port_a_cs1_capacity(cap[1]),
    .port_b_cs0_capacity(cap[2]), .port_b_cs1_capacity(cap[3]),
    .port_a_cs1_present(a1_on), .port_b_cs0_present(b0_on),
    .port_b_cs1_present(b1_on), .clock_class(clock_class),
    .busy_level(busy_level), .busy_position(busy_position),
    .lane_width(lane_width), .second_flash_port_enable(port_b_on),
    .ddr_enable(ddr_on), .first_port_second_select_enable(a1_sel),
    .flash_status(flash_status), .flash_busy(flash_busy));
  sfcl_record_model i_sfcl_record_model (.clock(clock), .rst_n(rst_n),
    .wait_cycles(wait_cycles), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic close_out();
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin // Some twentyfold the whole run
      fails++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Record i; zero capacity when absent, enable follows capacity
  task automatic fill(input int i, input logic [31:0] tag);
    i_sfcl_record_model.mem[0]  = tag;
    i_sfcl_record_model.mem[13] = 32'h01000000 + i;
    i_sfcl_record_model.mem[14] = i[0] ? 32'h00800000 : 32'h0;
    i_sfcl_record_model.mem[15] = i > 1 ? 32'h00400000 : 32'h0;
    i_sfcl_record_model.mem[16] = i == 3 ? 32'h0 : 32'hFFFFFFFC;
    i_sfcl_record_model.mem[17] = i % 3;
    i_sfcl_record_model.mem[18] = {15'h0, i[0], 16'(i * 10)};
    i_sfcl_record_model.mem[19] = i;
    i_sfcl_record_model.mem[20] = i & 1;
    i_sfcl_record_model.mem[21] = i & 1;
    i_sfcl_record_model.mem[24] = i & 1;
  endtask
  task automatic run_load(input logic [3:0] pace, input logic good);
    wait_cycles = pace;
    load_start  = 1'b1;
    @(negedge clock);
    load_start = 1'b0;
    check(load_busy, 1'b1, "not busy");
    for (int n = 0; n < 300 && load_done !== 1'b1; n++) @(negedge clock);
    check(load_done, 1'b1, "load never done");
    check(record_valid, good, "valid");
  endtask
  task automatic expect_settings(input int i);
    for (int k = 0; k < 4; k++)
      check(cap[k], i_sfcl_record_model.mem[13 + k], "capacity");
    check(a1_on, i[0], "a1 present");
    check(b0_on, i > 1, "b0 present");
    check(b1_on, i != 3, "b1 present");
    check(clock_class, i % 3, "clock class");
    check(busy_level, !i[0], "busy level");
    check(busy_position, i * 10, "busy position");
    check(lane_width, i, "lane width");
    check(port_b_on, i[0], "port enable");
    check(ddr_on, i[0], "ddr select");
    check(a1_sel, i[0], "a1 select enable");
    flash_status = 32'h1 << (i * 10);
    @(negedge clock) check(flash_busy, !i[0], "busy bit set");
    flash_status = ~flash_status;
    @(negedge clock) check(flash_busy, i[0], "busy bit clear");
  endtask
  task automatic t_reset();
    check(load_busy, 1'b0, "reset busy");
    check(record_valid, 1'b0, "reset valid");
    check(cap[0], 32'h0, "reset cap");
    check(busy_level, 1'b1, "reset level");
  endtask
  task automatic t_loads();
    for (int i = 0; i < 4; i++) begin
      fill(i, TAG_VALUE);
      run_load(i[0] ? 4'h5 : 4'h0, 1'b1);
      expect_settings(i);
    end
  endtask
  // Wrong tag leaves all earlier settings in place
  task automatic t_bad_tag();
    fill(2, 32'h6B716366);
    run_load(4'h2, 1'b0);
    fill(3, TAG_VALUE);
    expect_settings(3);
  endtask
  initial begin
    rst_n        = 1'b0;
    load_start   = 1'b0;
    flash_status = 32'h0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_loads();
    t_bad_tag();
    close_out();
  end
endmodule
